// ### hdl/dsk_pkg.sv
// Constants and carrier types shared by the diskette status and control bank.
// Assumes one 25 MHz clock and an AHB-Lite master that only makes word transfers.
package dsk_pkg;

   // ****************************************************************
   // Register indices; the byte address is four times the index.
   // ****************************************************************
   localparam logic [9:0] DSK_IDX_STAT_A = 10'h3f0;
   localparam logic [9:0] DSK_IDX_STAT_B = 10'h3f1;
   localparam logic [9:0] DSK_IDX_MOTOR = 10'h3f2;
   localparam logic [9:0] DSK_IDX_SHARED = 10'h3f7;
   localparam logic [9:0] DSK_IDX_EVT_STAT = 10'h3f8;
   localparam logic [9:0] DSK_IDX_EVT_CLR = 10'h3f9;
   localparam logic [9:0] DSK_IDX_EVT_EN = 10'h3fa;

   // ****************************************************************
   // Field positions.
   // ****************************************************************
   localparam int DSK_SA_INT = 7;
   localparam int DSK_SA_DRV2_N = 6;
   localparam int DSK_SA_STEP = 5;
   localparam int DSK_SA_TRK0_N = 4;
   localparam int DSK_SA_HEAD1 = 3;
   localparam int DSK_SA_INDEX_N = 2;
   localparam int DSK_SA_WPROT_N = 1;
   localparam int DSK_SA_DIR = 0;
   localparam int DSK_SB_SEL = 5;
   localparam int DSK_SB_WDATA = 4;
   localparam int DSK_SB_RDATA = 3;
   localparam int DSK_SB_WREN = 2;
   localparam int DSK_MC_MOTOR1 = 5;
   localparam int DSK_MC_MOTOR0 = 4;
   localparam int DSK_MC_CRESET = 2;
   localparam int DSK_MC_SEL = 0;
   localparam int DSK_DI_CHANGE = 7;
   localparam int DSK_DI_HD_N = 0;
   localparam int DSK_EV_RDATA = 0;
   localparam int DSK_EV_WDATA = 1;
   localparam int DSK_EV_CHANGE = 2;
   localparam int DSK_EV_W = 3;

   // ****************************************************************
   // Reset values and encodings.
   // ****************************************************************
   localparam logic [7:0] DSK_MOTOR_RESET = 8'h00;
   localparam logic [1:0] DSK_RATE_500K = 2'h0;
   localparam logic [1:0] DSK_RATE_250K = 2'h2;
   localparam logic DSK_HD_RESET = 1'b1;

   // ****************************************************************
   // Timing and density figures.
   // ****************************************************************
   localparam int DSK_CLK_NS = 40;
   localparam int DSK_PRECOMP_NS = 125;
   localparam logic [2:0] DSK_PRECOMP_CYC = 3'((DSK_PRECOMP_NS + DSK_CLK_NS - 1) / DSK_CLK_NS);
   localparam logic [3:0] DSK_HD_CLK_MHZ = 4'h8;
   localparam logic [3:0] DSK_LD_CLK_MHZ = 4'h4;
   localparam logic [1:0] DSK_HD_STEP_SCALE = 2'h1;
   localparam logic [1:0] DSK_LD_STEP_SCALE = 2'h2;
   localparam logic [4:0] DSK_HD_SECTORS = 5'h12;
   localparam logic [4:0] DSK_LD_SECTORS = 5'h09;

   // ****************************************************************
   // Carrier types.
   // ****************************************************************
   // Drive cable inputs, asynchronous to hclk.
   typedef struct packed {
      logic index_n;
      logic track0_n;
      logic wprot_n;
      logic drive2_n;
      logic change;
      logic hd_sel_n;
      logic rdata_n;
   } dsk_pins_t;

   // Controller core signals on hclk.
   typedef struct packed {
      logic int_pend;
      logic step;
      logic dir;
      logic head1;
      logic wr_en;
      logic wdata_n;
   } dsk_core_t;

   // Drive control outputs.
   typedef struct packed {
      logic [1:0] motor_en;
      logic drive_sel;
      logic ctrl_reset;
      logic reduced_wc;
      logic hd_mode;
   } dsk_drv_t;

   // Density dependent settings for the controller core.
   typedef struct packed {
      logic [3:0] clk_mhz;
      logic [1:0] step_scale;
      logic [4:0] sectors;
      logic [2:0] precomp;
   } dsk_rate_t;

endpackage

// ### hdl/dsk_regs.sv
// Host status and control bank of a two-drive diskette controller on AHB-Lite.
// Assumes drive pins are asynchronous and core signals run on hclk.
//
// Our own choice: the AHB-Lite register port.
module dsk_regs
   import dsk_pkg::*;
#(
   parameter int ADDR_W = 32
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire dsk_pins_t pins,
   input wire dsk_core_t core,
   output dsk_drv_t drv,
   output dsk_rate_t rate,
   output logic irq
);

   // ****************************************************************
   // Declarations.
   // ****************************************************************
   dsk_pins_t pin_q; // Synchronised drive pins.
   dsk_pins_t pin_rise; // Rising edges of drive pins.
   logic ap_take; // A transfer is taken this cycle.
   logic [9:0] ap_idx; // Register index of the address phase.
   logic ap_map; // Address lies in the decoded window.
   logic dp_wr_reg; // A write data phase is under way.
   logic [9:0] dp_idx_reg; // Index held for the data phase.
   logic [7:0] motor_reg; // Motor and select control.
   logic hd_reg; // High density selected.
   logic wdata_q_reg; // Previous write-data level.
   logic wdata_rise; // Rising edge of the write-data line.
   logic stb_wd_reg; // Write-data edge latch.
   logic stb_rd_reg; // Read-data edge latch.
   logic rd_b; // Status B is read this cycle.
   logic [DSK_EV_W-1:0] evt_reg; // Sticky event bits.
   logic [DSK_EV_W-1:0] evt_en_reg; // Event enables.
   logic [DSK_EV_W-1:0] evt_set; // Events this cycle.
   logic [DSK_EV_W-1:0] evt_clr; // Clear strobes this cycle.
   logic [7:0] rd_word; // Read value chosen in the address phase.

   // The decoder needs bits eleven down to two.
   if (ADDR_W < 12)
   begin : g_bad_addr
      $error("dsk_regs address width must be at least twelve");
   end

   // ****************************************************************
   // Pin synchronisers.
   // ****************************************************************
   // Every drive pin passes two flip-flops before use.
   dsk_sync #(
      .W($bits(dsk_pins_t))
   ) u_sync (
      .clk(hclk),
      .rst_n(hresetn),
      .d(pins),
      .q(pin_q),
      .rise(pin_rise)
   );

   // ****************************************************************
   // Bus address phase.
   // ****************************************************************
   // Only NONSEQ and SEQ transfers with hready high are taken.
   assign ap_take = hsel && htrans[1] && hready;
   assign ap_idx = haddr[11:2];

   // Anything above the window aliases nothing and reads zero.
   assign ap_map = (haddr[ADDR_W-1:12] == '0);

   // Hold the write target for the following data phase.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dp_wr_reg <= 1'b0;
         dp_idx_reg <= 10'h000;
      end
      else if (hready)
      begin
         // An unmapped write is dropped here, so it touches nothing.
         dp_wr_reg <= ap_take && hwrite && ap_map;
         dp_idx_reg <= ap_idx;
      end
   end

   // The slave never inserts wait states and never errors.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // ****************************************************************
   // Read multiplexer.
   // ****************************************************************
   // Reads are taken in the address phase so hrdata comes from a flop.
   always_comb
   begin
      rd_word = 8'h00;
      if (ap_map)
      begin
         case (ap_idx)
            DSK_IDX_STAT_A:
            begin
               rd_word[DSK_SA_INT] = core.int_pend;
               rd_word[DSK_SA_DRV2_N] = pin_q.drive2_n;
               rd_word[DSK_SA_STEP] = core.step;
               rd_word[DSK_SA_TRK0_N] = pin_q.track0_n;
               rd_word[DSK_SA_HEAD1] = core.head1;
               rd_word[DSK_SA_INDEX_N] = pin_q.index_n;
               rd_word[DSK_SA_WPROT_N] = pin_q.wprot_n;
               rd_word[DSK_SA_DIR] = core.dir;
            end
            DSK_IDX_STAT_B:
            begin
               rd_word[DSK_SB_WDATA] = stb_wd_reg;
               rd_word[DSK_SB_RDATA] = stb_rd_reg;
               rd_word[DSK_SB_WREN] = core.wr_en;
               rd_word[DSK_SB_SEL] = drv.drive_sel;
               rd_word[1:0] = drv.motor_en;
            end
            DSK_IDX_SHARED:
            begin
               rd_word[DSK_DI_CHANGE] = pin_q.change;
               rd_word[DSK_DI_HD_N] = pin_q.hd_sel_n;
            end
            DSK_IDX_EVT_STAT:
            begin
               rd_word[DSK_EV_W-1:0] = evt_reg;
            end
            DSK_IDX_EVT_EN:
            begin
               rd_word[DSK_EV_W-1:0] = evt_en_reg;
            end
            default:
            begin
               // Write-only and unmapped words read as zero.
               rd_word = 8'h00;
            end
         endcase
      end
   end

   // Register the read value; bits above the byte read as zero.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata <= 32'h0000_0000;
      end
      else if (ap_take && !hwrite)
      begin
         hrdata <= {24'h00_0000, rd_word};
      end
   end

   // ****************************************************************
   // Motor and select control.
   // ****************************************************************
   // Only the defined bits are kept; reserved bits stay zero.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         motor_reg <= DSK_MOTOR_RESET;
      end
      else if (dp_wr_reg && dp_idx_reg == DSK_IDX_MOTOR)
      begin
         motor_reg <= 8'h00;
         motor_reg[DSK_MC_MOTOR1] <= hwdata[DSK_MC_MOTOR1];
         motor_reg[DSK_MC_MOTOR0] <= hwdata[DSK_MC_MOTOR0];
         motor_reg[DSK_MC_CRESET] <= hwdata[DSK_MC_CRESET];
         motor_reg[DSK_MC_SEL] <= hwdata[DSK_MC_SEL];
      end
   end

   // ****************************************************************
   // Rate selection.
   // ****************************************************************
   // Reserved rate codes are ignored so the media timing never goes
   // undefined; software must still match density to the media.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hd_reg <= DSK_HD_RESET;
      end
      else if (dp_wr_reg && dp_idx_reg == DSK_IDX_SHARED)
      begin
         case (hwdata[1:0])
            DSK_RATE_500K:
            begin
               hd_reg <= 1'b1;
            end
            DSK_RATE_250K:
            begin
               hd_reg <= 1'b0;
            end
            default:
            begin
               hd_reg <= hd_reg;
            end
         endcase
      end
   end

   // Density dependent settings for the core.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rate <= '{DSK_HD_CLK_MHZ, DSK_HD_STEP_SCALE, DSK_HD_SECTORS, DSK_PRECOMP_CYC};
      end
      else
      begin
         rate.clk_mhz <= hd_reg ? DSK_HD_CLK_MHZ : DSK_LD_CLK_MHZ;
         rate.step_scale <= hd_reg ? DSK_HD_STEP_SCALE : DSK_LD_STEP_SCALE;
         rate.sectors <= hd_reg ? DSK_HD_SECTORS : DSK_LD_SECTORS;
         rate.precomp <= DSK_PRECOMP_CYC;
      end
   end

   // Drive cable outputs follow the control flops one cycle later.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         drv <= '0;
      end
      else
      begin
         drv.motor_en <= {motor_reg[DSK_MC_MOTOR1], motor_reg[DSK_MC_MOTOR0]};
         drv.drive_sel <= motor_reg[DSK_MC_SEL];
         drv.ctrl_reset <= motor_reg[DSK_MC_CRESET];
         drv.reduced_wc <= hd_reg;
         drv.hd_mode <= hd_reg;
      end
   end

   // ****************************************************************
   // Data line edge latches.
   // ****************************************************************
   // The write-data line comes from the core on hclk, so no synchroniser.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wdata_q_reg <= 1'b1;
      end
      else
      begin
         wdata_q_reg <= core.wdata_n;
      end
   end

   assign wdata_rise = core.wdata_n && !wdata_q_reg;
   assign rd_b = ap_take && !hwrite && ap_map && ap_idx == DSK_IDX_STAT_B;

   // A read of status B clears both latches; a new edge wins.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         stb_wd_reg <= 1'b0;
         stb_rd_reg <= 1'b0;
      end
      else
      begin
         stb_wd_reg <= wdata_rise || (stb_wd_reg && !rd_b);
         stb_rd_reg <= pin_rise.rdata_n || (stb_rd_reg && !rd_b);
      end
   end

   // ****************************************************************
   // Interrupt events.
   // ****************************************************************
   assign evt_set[DSK_EV_RDATA] = pin_rise.rdata_n;
   assign evt_set[DSK_EV_WDATA] = wdata_rise;
   assign evt_set[DSK_EV_CHANGE] = pin_rise.change;
   assign evt_clr = (dp_wr_reg && dp_idx_reg == DSK_IDX_EVT_CLR) ? hwdata[DSK_EV_W-1:0] : '0;

   // Sticky status; a set in the clearing cycle is kept.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         evt_reg <= '0;
      end
      else
      begin
         evt_reg <= evt_set | (evt_reg & ~evt_clr);
      end
   end

   // Enables are plain read-write storage.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         evt_en_reg <= '0;
      end
      else if (dp_wr_reg && dp_idx_reg == DSK_IDX_EVT_EN)
      begin
         evt_en_reg <= hwdata[DSK_EV_W-1:0];
      end
   end

   // The level output lags the status by one cycle to stay a flop.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         irq <= 1'b0;
      end
      else
      begin
         irq <= |(evt_reg & evt_en_reg);
      end
   end

   // ****************************************************************
   // Assertions.
   // ****************************************************************
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // A write data phase to a given index.
   sequence s_wr(logic [9:0] idx);
      dp_wr_reg && dp_idx_reg == idx;
   endsequence

   // A read address phase to a given index.
   sequence s_rd(logic [9:0] idx);
      ap_take && !hwrite && ap_map && ap_idx == idx;
   endsequence

   property p_rate_decode;
      s_wr(DSK_IDX_SHARED) ##0 (hwdata[1:0] == DSK_RATE_250K) |=> !hd_reg ##1 !drv.hd_mode;
   endproperty
   a_rate_decode: assert property (p_rate_decode) else $error("rate 250k not selected");

   property p_precomp;
      rate.precomp == 3'h4;
   endproperty
   a_precomp: assert property (p_precomp) else $error("precompensation count wrong");

   property p_clock;
      hd_reg |=> (rate.clk_mhz == 4'h8) && (rate.step_scale == 2'h1);
   endproperty
   a_clock: assert property (p_clock) else $error("high density clock wrong");

   property p_sectors;
      !hd_reg |=> rate.sectors == 5'h09;
   endproperty
   a_sectors: assert property (p_sectors) else $error("low density sectors wrong");

   property p_current;
      hresetn |=> drv.reduced_wc == $past(hd_reg);
   endproperty
   a_current: assert property (p_current) else $error("write current not following density");

   property p_stat_a;
      s_rd(DSK_IDX_STAT_A) |=> hrdata[DSK_SA_TRK0_N] == $past(pin_q.track0_n);
   endproperty
   a_stat_a: assert property (p_stat_a) else $error("status A track zero wrong");

   property p_wlatch;
      wdata_rise |=> stb_wd_reg;
   endproperty
   a_wlatch: assert property (p_wlatch) else $error("write-data edge lost");

   property p_rlatch;
      pin_rise.rdata_n |=> stb_rd_reg;
   endproperty
   a_rlatch: assert property (p_rlatch) else $error("read-data edge lost");

   property p_motor;
      s_wr(DSK_IDX_MOTOR) ##0 hwdata[DSK_MC_MOTOR1] |=> ##1 drv.motor_en[1];
   endproperty
   a_motor: assert property (p_motor) else $error("motor one not driven");

   property p_din;
      s_rd(DSK_IDX_SHARED) |=> hrdata[6:1] == 6'h00;
   endproperty
   a_din: assert property (p_din) else $error("shared read reserved bits set");

   property p_mirror;
      s_rd(DSK_IDX_STAT_B) |=> hrdata[DSK_SB_SEL] == $past(drv.drive_sel);
   endproperty
   a_mirror: assert property (p_mirror) else $error("status B select mismatch");

endmodule

// ### hdl/dsk_sync.sv
// Two-stage synchroniser with a rising edge detector behind it.
// Assumes inputs are asynchronous to clk and may change at any time.
module dsk_sync
   import dsk_pkg::*;
#(
   parameter int W = 1
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q,
   output logic [W-1:0] rise
);

   // ****************************************************************
   // Stages.
   // ****************************************************************
   logic [W-1:0] s1_reg; // Metastable stage, read only by s2_reg.
   logic [W-1:0] s2_reg; // Settled level.
   logic [W-1:0] s3_reg; // Delayed level for the edge detector.
   logic [2:0] arm_reg; // Fills with ones as real levels reach the third stage.

   // A zero width would leave the block with nothing to carry.
   if (W < 1)
   begin : g_bad_width
      $error("dsk_sync width must be at least one");
   end

   // Shift the inputs through three flip-flops.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end
      else
      begin
         s1_reg <= d;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // Edges are held off until the third stage holds a real pin level.
   // Without this the reset zeros would read as a rise on idle-high lines.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         arm_reg <= 3'h0;
      end
      else
      begin
         arm_reg <= {arm_reg[1:0], 1'b1};
      end
   end

   // The edge looks only at settled stages.
   assign q = s2_reg;
   assign rise = s2_reg & ~s3_reg & {W{arm_reg[2]}};

endmodule

// ### tb/dsk_drive_model.sv
// Behavioural diskette drive on the cable side of the status bank.
// Assumes step and direction come from the core on hclk; other lines follow the bench, except track zero, which follows the head.
module dsk_drive_model
   import dsk_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire dsk_core_t core,
   input wire dsk_pins_t want,
   output dsk_pins_t pins
);
   timeunit 1ns;
   timeprecision 1ns;
   // Head position; the bench never sets track zero directly.
   logic [6:0] trk_reg;
   // Last step level, for edge detection.
   logic step_reg;
   // One track per rising step; direction high moves inward, outward stops at zero.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         trk_reg <= 7'h00;
         step_reg <= 1'b0;
      end
      else
      begin
         step_reg <= core.step;
         if (core.step && !step_reg)
            trk_reg <= core.dir ? trk_reg + 7'h01 : trk_reg - 7'(trk_reg != 7'h00);
      end
   end
   // The track zero sensor follows the head, so a stuck head shows up in status.
   always_comb
   begin
      pins = want;
      pins.track0_n = (trk_reg != 7'h00);
   end
endmodule

// ### tb/tb_diskette_host_status_control_regs.sv
// Self-checking bench for the diskette status and control bank.
// Assumes the AHB slave is the only one on the bus and answers in its own time.
module tb_diskette_host_status_control_regs;
   timeunit 1ns;
   timeprecision 1ns;
   import dsk_pkg::*;
   logic hclk, hresetn, hwrite, hreadyout, hresp, irq;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, rd;
   dsk_core_t core;
   dsk_pins_t want, pins;
   dsk_drv_t drv;
   dsk_rate_t rate;
   int n_mismatch = 0;
   int tests_run = 0;
   int cyc = 0;
   dsk_regs dsk_regs_i (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .pins(pins), .core(core), .drv(drv), .rate(rate), .irq(irq));
   dsk_drive_model dsk_drive_model_i (.hclk(hclk), .hresetn(hresetn), .core(core), .want(want),
      .pins(pins));
   // ****************************************************************
   // Clock, timeout and shared tasks.
   // ****************************************************************
   initial
   begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   // A hung handshake would otherwise stall the run forever.
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_mismatch++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One single word transfer; the address phase holds until hready is seen high.
   task automatic bus(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
      @(posedge hclk);
      haddr <= {20'h0, idx, 2'b00};
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rdc(input logic [9:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 32'h0);
      chk(rd, {24'h0, exp});
   endtask
   // ****************************************************************
   // Scenarios.
   // ****************************************************************
   task automatic t_reset();
      chk({drv.motor_en, drv.drive_sel, drv.ctrl_reset}, 0);
      chk(rate, {DSK_HD_CLK_MHZ, DSK_HD_STEP_SCALE, DSK_HD_SECTORS, 3'h4});
      chk({hreadyout, hresp}, 2'b10);
      rdc(DSK_IDX_MOTOR, 8'h00);
      rdc(10'h3f5, 8'h00);
      // No edges reach the latches while the lines settle out of reset; this read leaves them clear.
      bus(1'b0, DSK_IDX_STAT_B, 32'h0);
   endtask
   // Codes 01 and 11 must leave the density as it was.
   task automatic t_rate();
      logic [1:0] codes [4] = '{2'h2, 2'h1, 2'h0, 2'h3};
      logic hd [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
      for (int i = 0; i < 4; i++)
      begin
         bus(1'b1, DSK_IDX_SHARED, {24'h0, 6'h3f, codes[i]});
         repeat (2) @(posedge hclk);
         chk(rate, hd[i] ? {DSK_HD_CLK_MHZ, DSK_HD_STEP_SCALE, DSK_HD_SECTORS, 3'h4}
            : {DSK_LD_CLK_MHZ, DSK_LD_STEP_SCALE, DSK_LD_SECTORS, 3'h4});
         chk({drv.reduced_wc, drv.hd_mode}, {hd[i], hd[i]});
      end
   endtask
   task automatic t_stat();
      core <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
      want <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
      repeat (4) @(posedge hclk);
      rdc(DSK_IDX_STAT_A, 8'h8d);
      rdc(DSK_IDX_SHARED, 8'h80);
      core.step <= 1'b1;
      repeat (2) @(posedge hclk);
      core <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
      want <= '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
      repeat (4) @(posedge hclk);
      rdc(DSK_IDX_STAT_A, 8'h52);
      rdc(DSK_IDX_SHARED, 8'h01);
   endtask
   task automatic t_motor();
      core.wr_en <= 1'b1;
      bus(1'b1, DSK_IDX_MOTOR, 32'h35);
      repeat (2) @(posedge hclk);
      chk({drv.motor_en, drv.drive_sel, drv.ctrl_reset}, 4'hf);
      rdc(DSK_IDX_STAT_B, 8'h27);
      core.wr_en <= 1'b0;
      bus(1'b1, DSK_IDX_MOTOR, 32'h11);
      repeat (2) @(posedge hclk);
      chk({drv.motor_en, drv.drive_sel, drv.ctrl_reset}, 4'h6);
      rdc(DSK_IDX_STAT_B, 8'h21);
   endtask
   // Write-data edge is masked, read-data edge raises the interrupt.
   task automatic t_latch();
      bus(1'b1, DSK_IDX_EVT_CLR, 32'h7);
      bus(1'b1, DSK_IDX_EVT_EN, 32'h1);
      core.wdata_n <= 1'b0;
      @(posedge hclk);
      core.wdata_n <= 1'b1;
      repeat (4) @(posedge hclk);
      chk(irq, 1'b0);
      rdc(DSK_IDX_STAT_B, 8'h31);
      want.rdata_n <= 1'b0;
      repeat (4) @(posedge hclk);
      want.rdata_n <= 1'b1;
      repeat (6) @(posedge hclk);
      chk(irq, 1'b1);
      rdc(DSK_IDX_STAT_B, 8'h29);
      rdc(DSK_IDX_STAT_B, 8'h21);
      rdc(DSK_IDX_EVT_STAT, 8'h03);
      bus(1'b1, DSK_IDX_EVT_CLR, 32'h3);
      repeat (2) @(posedge hclk);
      chk(irq, 1'b0);
      rdc(DSK_IDX_EVT_STAT, 8'h00);
   endtask
   initial
   begin
      hresetn = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hwdata = 32'h0;
      core = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
      // Density resets high though the drive reports low density media (hd_sel_n high).
      want = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_rate();
      t_stat();
      t_motor();
      t_latch();
      give_verdict();
   end
endmodule
